//--- core/opmode_pkg.sv
/*
  Constants, field positions and types shared by the operating mode block.
  Assumes byte addressing on the register port and 32-bit data.
*/
package opmode_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] TX_LIST_BASE_OFS = 8'h20;
  localparam logic [7:0] STATUS_OFS = 8'h28;
  localparam logic [7:0] OPMODE_OFS = 8'h30;

  // ****************************************
  // Operating mode field positions
  // ****************************************
  localparam int ENH_CAPTURE_BIT = 31;
  localparam int ACCEPT_ALL_BIT = 30;
  localparam int FIXED_ONE_BIT = 25;
  localparam int WHITENING_BIT = 24;
  localparam int LINE_CODE_BIT = 23;
  localparam int SPEED_SEL_BIT = 22;
  localparam int WHOLE_PKT_BIT = 21;
  localparam int HEARTBEAT_DIS_BIT = 19;
  localparam int PORT_SEL_BIT = 18;
  localparam int CAPTURE_BIT = 17;
  localparam int LEVEL_HI_BIT = 15;
  localparam int LEVEL_LO_BIT = 14;
  localparam int TX_RUN_BIT = 13;
  localparam int FORCE_COL_BIT = 12;
  localparam int LOOP_HI_BIT = 11;
  localparam int LOOP_LO_BIT = 10;

  // ****************************************
  // Status field positions
  // ****************************************
  localparam int TX_STATE_HI_BIT = 22;
  localparam int TX_STATE_LO_BIT = 20;
  localparam int TX_UNAVAIL_BIT = 2;
  localparam int TX_STOPPED_BIT = 1;

  // ****************************************
  // Reset values, masks, internal loopback code and attempt limit
  // ****************************************
  localparam logic [31:0] OPMODE_RESET = 32'h0000_0000;
  localparam logic [31:0] OPMODE_WMASK = 32'hC3EE_FC00;
  localparam logic [31:0] TX_LIST_BASE_RESET = 32'h0000_0000;
  localparam logic [31:0] STATUS_W1C_MASK = 32'h0001_FFFF;
  localparam logic [1:0] LOOP_INTERNAL = 2'b01;
  localparam logic [4:0] ATTEMPT_LIMIT = 5'h10;

  // ****************************************
  // Transmit process state codes as read back
  // ****************************************
  localparam logic [2:0] CODE_STOPPED = 3'h0;
  localparam logic [2:0] CODE_FETCH = 3'h1;
  localparam logic [2:0] CODE_WAIT_END = 3'h2;
  localparam logic [2:0] CODE_QUEUE = 3'h3;
  localparam logic [2:0] CODE_SUSPENDED = 3'h6;
  localparam logic [2:0] CODE_CLOSE = 3'h7;

  typedef enum logic [2:0] {
    TX_STOPPED, TX_FETCH, TX_QUEUE, TX_SEND, TX_CLOSE, TX_SUSPENDED
  } txstate_t;

endpackage

//--- core/opmode_ctrl.sv
/*
  Operating mode register with the transmit process control that it steers.
  Assumes a descriptor engine and a transmit FIFO beside it, and a PHY on the
  selected port; all inputs are synchronous to ref_clk.
*/
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ns

module opmode_ctrl #(
  parameter int LEVEL_W = 12,
  parameter logic [LEVEL_W-1:0] THR100_0 = 'd128,
  parameter logic [LEVEL_W-1:0] THR100_1 = 'd256,
  parameter logic [LEVEL_W-1:0] THR100_2 = 'd512,
  parameter logic [LEVEL_W-1:0] THR100_3 = 'd1024,
  parameter logic [LEVEL_W-1:0] THR10_0 = 'd72,
  parameter logic [LEVEL_W-1:0] THR10_1 = 'd96,
  parameter logic [LEVEL_W-1:0] THR10_2 = 'd128,
  parameter logic [LEVEL_W-1:0] THR10_3 = 'd160
) (
  input wire logic ref_clk, // Clock, 125 MHz
  input wire logic nrst, // Hardware reset, active low
  input wire logic clkEn, // Freezes all state while low
  input wire logic swReset, // Software reset pulse
  input wire logic [7:0] regAddr, // Register byte address
  input wire logic [31:0] regWrData, // Write data
  input wire logic regWr, // Write strobe
  input wire logic regRd, // Read strobe
  output logic [31:0] regRdData, // Read data, cycle after strobe
  input wire logic descDone, // Descriptor fetch finished
  input wire logic descOwned, // Fetched descriptor owned by device
  input wire logic pollDemand, // Resume from suspended
  input wire logic [LEVEL_W-1:0] fifoLevel, // Bytes of frame in FIFO
  input wire logic frameInFifo, // Whole frame held in FIFO
  input wire logic frameEnd, // Transmission of frame finished
  input wire logic collisionSeen, // Collision on one attempt
  input wire logic [31:0] nextDescAddr, // Position after current descriptor
  output logic fetchReq, // Fetch descriptor at descAddr
  output logic [31:0] descAddr, // Current list position
  output logic txStart, // Begin sending frame
  output logic excessCollision, // Attempt limit reached
  output logic enhCaptureEn, // Enhanced capture resolution
  output logic captureEn, // Capture-effect resolution
  output logic acceptAll, // Receive every packet
  output logic whiteningEn, // Scrambler on
  output logic lineCodeMode, // Coding sublayer on
  output logic heartbeatEn, // Heartbeat generator on
  output logic mediaPortSel, // High selects MII/line-code port
  output logic [1:0] loopbackSel, // Loopback mode
  output logic forceCollision // Force collision on attempts, in internal loopback only
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [31:0] opMode;
    logic [31:0] txBase;
    logic [31:0] curAddr;
    opmode_pkg::txstate_t txState;
    logic txUnavail;
    logic txStoppedFlag;
    logic stopPend;
    logic [4:0] attempts;
    logic excessCol;
    logic [31:0] rdData;
  } state_t;

  state_t s_q;
  state_t s_d;

  // Default thresholds need 11 bits; wider levels than 16 are not served
  if (LEVEL_W < 11 || LEVEL_W > 16) begin : gen_bad_width
    $error("LEVEL_W out of range");
  end

  function automatic logic [2:0] stateCode(opmode_pkg::txstate_t st);
    case (st)
      opmode_pkg::TX_STOPPED: stateCode = opmode_pkg::CODE_STOPPED;
      opmode_pkg::TX_FETCH: stateCode = opmode_pkg::CODE_FETCH;
      opmode_pkg::TX_QUEUE: stateCode = opmode_pkg::CODE_QUEUE;
      opmode_pkg::TX_SEND: stateCode = opmode_pkg::CODE_WAIT_END;
      opmode_pkg::TX_CLOSE: stateCode = opmode_pkg::CODE_CLOSE;
      opmode_pkg::TX_SUSPENDED: stateCode = opmode_pkg::CODE_SUSPENDED;
      default: stateCode = opmode_pkg::CODE_STOPPED;
    endcase
  endfunction

  function automatic logic [LEVEL_W-1:0] threshold(logic tenMb, logic [1:0] lvl);
    case ({tenMb, lvl})
      3'h0: threshold = THR100_0;
      3'h1: threshold = THR100_1;
      3'h2: threshold = THR100_2;
      3'h3: threshold = THR100_3;
      3'h4: threshold = THR10_0;
      3'h5: threshold = THR10_1;
      3'h6: threshold = THR10_2;
      default: threshold = THR10_3;
    endcase
  endfunction

  // ****************************************
  // Decode
  // ****************************************
  logic wrMode;
  logic wrBase;
  logic wrStatus;
  logic runNew;
  logic stopNew;
  logic sendGo;
  logic [LEVEL_W-1:0] thrBytes;
  logic [31:0] statusWord;

  assign wrMode = regWr && regAddr == opmode_pkg::OPMODE_OFS;
  assign wrBase = regWr && regAddr == opmode_pkg::TX_LIST_BASE_OFS;
  assign wrStatus = regWr && regAddr == opmode_pkg::STATUS_OFS;
  assign runNew = wrMode && regWrData[opmode_pkg::TX_RUN_BIT];
  assign stopNew = wrMode && !regWrData[opmode_pkg::TX_RUN_BIT];

  assign thrBytes = threshold(s_q.opMode[opmode_pkg::SPEED_SEL_BIT],
    s_q.opMode[opmode_pkg::LEVEL_HI_BIT:opmode_pkg::LEVEL_LO_BIT]);

  assign sendGo = s_q.opMode[opmode_pkg::WHOLE_PKT_BIT] ? frameInFifo :
    (frameInFifo || fifoLevel > thrBytes);

  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[opmode_pkg::TX_STATE_HI_BIT:opmode_pkg::TX_STATE_LO_BIT] =
      stateCode(s_q.txState);
    statusWord[opmode_pkg::TX_UNAVAIL_BIT] = s_q.txUnavail;
    statusWord[opmode_pkg::TX_STOPPED_BIT] = s_q.txStoppedFlag;
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.rdData = 32'h0000_0000;
    if (regRd) begin
      case (regAddr)
        opmode_pkg::OPMODE_OFS: s_d.rdData = s_q.opMode;
        opmode_pkg::TX_LIST_BASE_OFS: s_d.rdData = s_q.txBase;
        opmode_pkg::STATUS_OFS: s_d.rdData = statusWord;
        default: s_d.rdData = 32'h0000_0000;
      endcase
    end
    if (wrMode) begin
      s_d.opMode = regWrData & opmode_pkg::OPMODE_WMASK;
    end
    if (wrBase) begin
      s_d.txBase = regWrData;
    end
    if (wrStatus) begin
      if (regWrData[opmode_pkg::TX_UNAVAIL_BIT]) begin
        s_d.txUnavail = 1'b0;
      end
      if (regWrData[opmode_pkg::TX_STOPPED_BIT]) begin
        s_d.txStoppedFlag = 1'b0;
      end
    end
    case (s_q.txState)
      opmode_pkg::TX_STOPPED: begin
        if (wrBase) begin
          s_d.curAddr = regWrData;
        end
        if (runNew) begin
          s_d.txState = opmode_pkg::TX_FETCH;
          s_d.stopPend = 1'b0;
        end
      end
      opmode_pkg::TX_FETCH: begin
        if (descDone) begin
          if (!descOwned) begin
            s_d.txState = opmode_pkg::TX_SUSPENDED;
            s_d.txUnavail = 1'b1;
          end else begin
            s_d.txState = opmode_pkg::TX_QUEUE;
          end
        end
      end
      opmode_pkg::TX_QUEUE: begin
        if (sendGo) begin
          s_d.txState = opmode_pkg::TX_SEND;
          s_d.attempts = 5'h00;
          s_d.excessCol = 1'b0;
        end
      end
      opmode_pkg::TX_SEND: begin
        if (collisionSeen && s_q.attempts != opmode_pkg::ATTEMPT_LIMIT) begin
          s_d.attempts = s_q.attempts + 5'h01;
          if (s_q.attempts + 5'h01 == opmode_pkg::ATTEMPT_LIMIT) begin
            s_d.excessCol = 1'b1;
          end
        end
        if (frameEnd) begin
          s_d.txState = opmode_pkg::TX_CLOSE;
        end
      end
      opmode_pkg::TX_CLOSE: begin
        s_d.curAddr = nextDescAddr;
        if (s_q.stopPend || stopNew) begin
          s_d.txState = opmode_pkg::TX_STOPPED;
          s_d.txStoppedFlag = 1'b1;
          s_d.stopPend = 1'b0;
        end else begin
          s_d.txState = opmode_pkg::TX_FETCH;
        end
      end
      opmode_pkg::TX_SUSPENDED: begin
        if (stopNew) begin
          s_d.txState = opmode_pkg::TX_STOPPED;
          s_d.txStoppedFlag = 1'b1;
        end else if (pollDemand) begin
          s_d.txState = opmode_pkg::TX_FETCH;
        end
      end
      default: s_d.txState = opmode_pkg::TX_STOPPED;
    endcase
    if (stopNew && s_q.txState inside {opmode_pkg::TX_FETCH,
        opmode_pkg::TX_QUEUE, opmode_pkg::TX_SEND}) begin
      s_d.stopPend = 1'b1;
    end
    if (swReset) begin
      s_d = '0;
      s_d.opMode = opmode_pkg::OPMODE_RESET;
      s_d.opMode[opmode_pkg::PORT_SEL_BIT] = s_q.opMode[opmode_pkg::PORT_SEL_BIT];
      s_d.txBase = opmode_pkg::TX_LIST_BASE_RESET;
      s_d.txState = opmode_pkg::TX_STOPPED;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.opMode <= opmode_pkg::OPMODE_RESET;
      s_q.txBase <= opmode_pkg::TX_LIST_BASE_RESET;
      s_q.txState <= opmode_pkg::TX_STOPPED;
    end else if (clkEn) begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign regRdData = s_q.rdData;
  assign descAddr = s_q.curAddr;
  assign fetchReq = s_q.txState == opmode_pkg::TX_FETCH;
  assign txStart = clkEn && s_q.txState == opmode_pkg::TX_QUEUE && sendGo;
  assign excessCollision = s_q.excessCol;
  assign enhCaptureEn = s_q.opMode[opmode_pkg::ENH_CAPTURE_BIT];
  assign captureEn = s_q.opMode[opmode_pkg::CAPTURE_BIT];
  assign acceptAll = s_q.opMode[opmode_pkg::ACCEPT_ALL_BIT];
  assign whiteningEn = s_q.opMode[opmode_pkg::WHITENING_BIT];
  assign lineCodeMode = s_q.opMode[opmode_pkg::LINE_CODE_BIT];
  assign heartbeatEn = !s_q.opMode[opmode_pkg::HEARTBEAT_DIS_BIT];
  assign mediaPortSel = s_q.opMode[opmode_pkg::PORT_SEL_BIT];
  assign loopbackSel = s_q.opMode[opmode_pkg::LOOP_HI_BIT:opmode_pkg::LOOP_LO_BIT];
  assign forceCollision = s_q.opMode[opmode_pkg::FORCE_COL_BIT] &&
    loopbackSel == opmode_pkg::LOOP_INTERNAL;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  chk_start_stopped: assert property (
    clkEn && !swReset && runNew && s_q.txState != opmode_pkg::TX_STOPPED &&
    s_q.txState != opmode_pkg::TX_CLOSE && s_q.txState != opmode_pkg::TX_SUSPENDED
    |=> s_q.txState != opmode_pkg::TX_STOPPED)
    else $error("start changed a live transmit process");
  chk_start_fetch: assert property (
    clkEn && !swReset && runNew && s_q.txState == opmode_pkg::TX_STOPPED
    |=> fetchReq && descAddr == $past(s_q.curAddr))
    else $error("start did not fetch at current position");
  chk_unowned_suspend: assert property (
    clkEn && !swReset && fetchReq && descDone && !descOwned
    |=> s_q.txState == opmode_pkg::TX_SUSPENDED && s_q.txUnavail)
    else $error("unowned descriptor not suspended");
  chk_stop_saves: assert property (
    clkEn && !swReset && s_q.txState == opmode_pkg::TX_CLOSE && s_q.stopPend
    |=> s_q.txState == opmode_pkg::TX_STOPPED && descAddr == $past(nextDescAddr))
    else $error("stop did not save next position");
  chk_stop_ignored: assert property (
    clkEn && !swReset && stopNew && s_q.txState == opmode_pkg::TX_STOPPED
    |=> !s_q.stopPend && s_q.txState == opmode_pkg::TX_STOPPED)
    else $error("stop acted while stopped");
  chk_whole_packet: assert property (
    txStart && s_q.opMode[opmode_pkg::WHOLE_PKT_BIT] |-> frameInFifo)
    else $error("send began before whole packet");
  chk_threshold_go: assert property (
    txStart && !frameInFifo |-> fifoLevel > thrBytes)
    else $error("send began below threshold");
  chk_port_soft: assert property (
    clkEn && swReset |=> mediaPortSel == $past(mediaPortSel))
    else $error("software reset changed port select");
  chk_undef_zero: assert property (
    (s_q.opMode & ~opmode_pkg::OPMODE_WMASK) == 32'h0000_0000)
    else $error("undefined bits set");
  chk_excess_flag: assert property (
    clkEn && !swReset && s_q.txState == opmode_pkg::TX_SEND && collisionSeen &&
    s_q.attempts == 5'h0F |=> excessCollision)
    else $error("excess collision not flagged at limit");

endmodule // opmode_ctrl

//--- verification/tx_far_model.sv
/*
  Far-side model of the transmit path: descriptor fetch, frame drain, collisions.
  Assumes the control block's fetch and start handshakes on ref_clk.
*/
`timescale 1ns/1ns
module tx_far_model (
  input wire logic ref_clk, // Clock
  input wire logic nrst, // Sync reset, active low
  input wire logic fetchReq, // Fetch request
  input wire logic [31:0] descAddr, // Current list position
  input wire logic txStart, // Frame start
  input wire logic forceCollision, // Collide each attempt
  input wire logic ownedCfg, // Ownership to report
  input wire logic slow, // Long latencies
  output logic descDone, // Fetch finished
  output logic descOwned, // Ownership beside descDone
  output logic frameEnd, // Frame sent
  output logic collisionSeen, // One collided attempt
  output logic [31:0] nextDescAddr // Position after current one
);
  logic busy, sending;
  int fetchCnt, sendCnt, colCnt;
  // Ownership outside descDone shows the inverse
  assign descOwned = descDone ? ownedCfg : !ownedCfg;
  assign nextDescAddr = descAddr + 32'h0000_0010;
  always_ff @(posedge ref_clk) begin
    descDone <= 1'b0;
    frameEnd <= 1'b0;
    collisionSeen <= 1'b0;
    if (!nrst) begin
      busy <= 1'b0;
      sending <= 1'b0;
    end else begin
      if (fetchReq && !busy && !descDone) begin
        busy <= 1'b1;
        fetchCnt <= slow ? 5 : 1;
      end else if (busy) begin
        fetchCnt <= fetchCnt - 1;
        if (fetchCnt == 1) begin
          descDone <= 1'b1;
          busy <= 1'b0;
        end
      end
      if (txStart) begin
        sending <= 1'b1;
        sendCnt <= slow ? 12 : 4;
        colCnt <= 0;
      end else if (sending) begin
        if (forceCollision && colCnt < 16) begin
          collisionSeen <= !collisionSeen;
          colCnt <= collisionSeen ? colCnt : colCnt + 1;
        end else if (sendCnt == 0) begin
          frameEnd <= 1'b1;
          sending <= 1'b0;
        end else begin
          sendCnt <= sendCnt - 1;
        end
      end
    end
  end
endmodule // tx_far_model

//--- verification/opmode_ctrl_tb.sv
/*
  Self-checking bench for the operating mode block.
  Assumes the default threshold parameters and the far-side model beside it.
*/
`timescale 1ns/1ns
module opmode_ctrl_tb;
  logic ref_clk, nrst, clkEn, swReset, regWr, regRd, pollDemand, frameInFifo;
  logic ownedCfg, slow, descDone, descOwned, frameEnd, collisionSeen;
  logic fetchReq, txStart, excessCollision, enhCaptureEn, captureEn, acceptAll;
  logic whiteningEn, lineCodeMode, heartbeatEn, mediaPortSel, forceCollision;
  logic [1:0] loopbackSel;
  logic [7:0] regAddr;
  logic [11:0] fifoLevel;
  logic [31:0] regWrData, regRdData, descAddr, nextDescAddr;
  int err_total = 0;
  int total_checks = 0;
  int cycleCnt = 0;
  typedef struct {logic [31:0] wdat; logic [31:0] rdat; logic [9:0] outv;} row_t;
  row_t rows [9];
  localparam logic [7:0] OM = opmode_pkg::OPMODE_OFS;
  localparam logic [7:0] ST = opmode_pkg::STATUS_OFS;

  opmode_ctrl opmode_ctrl_i (.ref_clk(ref_clk), .nrst(nrst), .clkEn(clkEn),
    .swReset(swReset), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .descDone(descDone), .descOwned(descOwned),
    .pollDemand(pollDemand), .fifoLevel(fifoLevel), .frameInFifo(frameInFifo),
    .frameEnd(frameEnd), .collisionSeen(collisionSeen), .nextDescAddr(nextDescAddr),
    .fetchReq(fetchReq), .descAddr(descAddr), .txStart(txStart),
    .excessCollision(excessCollision), .enhCaptureEn(enhCaptureEn),
    .captureEn(captureEn), .acceptAll(acceptAll), .whiteningEn(whiteningEn),
    .lineCodeMode(lineCodeMode), .heartbeatEn(heartbeatEn),
    .mediaPortSel(mediaPortSel), .loopbackSel(loopbackSel),
    .forceCollision(forceCollision));

  tx_far_model tx_far_model_i (.ref_clk(ref_clk), .nrst(nrst), .fetchReq(fetchReq),
    .descAddr(descAddr), .txStart(txStart), .forceCollision(forceCollision),
    .ownedCfg(ownedCfg), .slow(slow), .descDone(descDone), .descOwned(descOwned),
    .frameEnd(frameEnd), .collisionSeen(collisionSeen), .nextDescAddr(nextDescAddr));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task stop_test();
    if (err_total == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycleCnt++;
    if (cycleCnt == 3000) begin
      err_total++;
      stop_test();
    end
  end

  task check(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string n);
    @(posedge ref_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1;
    check(n, e, regRdData & m);
  endtask

  function logic [9:0] outs();
    return {enhCaptureEn, captureEn, acceptAll, whiteningEn, lineCodeMode,
      heartbeatEn, mediaPortSel, loopbackSel, forceCollision};
  endfunction

  task waitHigh(input int sel, input string n);
    logic seen;
    seen = 1'b0;
    repeat (60) begin
      if (seen !== 1'b1) begin
        @(posedge ref_clk);
        #1;
        seen = (sel == 0) ? fetchReq : excessCollision;
      end
    end
    check(n, 32'h0000_0001, 32'(seen));
  endtask

  task noStart(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      #1;
      check("txStart held", 32'h0000_0000, 32'(txStart));
    end
  endtask

  task startNow(input logic [11:0] lvl, input logic whole);
    @(posedge ref_clk);
    fifoLevel <= lvl;
    frameInFifo <= whole;
    #1;
    check("txStart", 32'h0000_0001, 32'(txStart));
    @(posedge ref_clk);
    fifoLevel <= 12'h000;
    frameInFifo <= 1'b0;
  endtask

  initial begin
    {nrst, swReset, regWr, regRd, pollDemand, frameInFifo, slow} = '0;
    {clkEn, ownedCfg} = 2'b11;
    regAddr = 8'h00;
    regWrData = 32'h0000_0000;
    fifoLevel = 12'h000;
    // Every write keeps bit 25 set and bit 31 beside bit 17
    rows = '{'{32'h8202_0000, 32'h8202_0000, 10'h310},
      '{32'h4200_0000, 32'h4200_0000, 10'h090}, '{32'h0380_0000, 32'h0380_0000, 10'h070},
      '{32'h020C_0000, 32'h020C_0000, 10'h008}, '{32'h0200_1400, 32'h0200_1400, 10'h013},
      '{32'h0200_1800, 32'h0200_1800, 10'h014}, '{32'h0200_0C00, 32'h0200_0C00, 10'h016},
      '{32'h3E11_03FF, 32'h0200_0000, 10'h010}, '{32'h0260_C000, 32'h0260_C000, 10'h010}};
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    #1;
    check("reset outputs", 32'h0000_0010, 32'(outs()));
    rd(OM, 32'hFFFF_FFFF, 32'h0000_0000, "opmode reset");
    rd(ST, 32'h0070_0000, 32'h0000_0000, "state reset");
    foreach (rows[i]) begin
      wr(OM, rows[i].wdat);
      rd(OM, 32'hFFFF_FFFF, rows[i].rdat, "opmode readback");
      check("mode outputs", 32'(rows[i].outv), 32'(outs()));
    end
    wr(OM, 32'h0204_0000);
    @(posedge ref_clk);
    swReset <= 1'b1;
    @(posedge ref_clk);
    swReset <= 1'b0;
    #1;
    check("port after soft reset", 32'h0000_0001, 32'(mediaPortSel));
    rd(OM, 32'hFFFF_FFFF, 32'h0004_0000, "opmode soft reset");
    @(posedge ref_clk);
    nrst <= 1'b0;
    @(posedge ref_clk);
    nrst <= 1'b1;
    #1;
    check("port after hard reset", 32'h0000_0000, 32'(mediaPortSel));
    wr(opmode_pkg::TX_LIST_BASE_OFS, 32'h0000_1000);
    rd(opmode_pkg::TX_LIST_BASE_OFS, 32'hFFFF_FFFF, 32'h0000_1000, "list base");
    fifoLevel <= 12'h080;
    wr(OM, 32'h0200_2000);
    waitHigh(0, "fetch");
    check("fetch address", 32'h0000_1000, descAddr);
    noStart(6);
    rd(ST, 32'h0070_0000, 32'h0030_0000, "queue state");
    startNow(12'h081, 1'b0);
    wr(OM, 32'h0200_0000);
    repeat (12) @(posedge ref_clk);
    rd(ST, 32'h0070_0006, 32'h0000_0002, "stopped after frame");
    check("saved position", 32'h0000_1010, descAddr);
    wr(ST, 32'h0000_0006);
    rd(ST, 32'h0000_0006, 32'h0000_0000, "status cleared");
    slow <= 1'b1;
    fifoLevel <= 12'hFFF;
    wr(OM, 32'h0220_2000);
    waitHigh(0, "fetch saved");
    check("restart address", 32'h0000_1010, descAddr);
    noStart(10);
    startNow(12'h000, 1'b1);
    ownedCfg <= 1'b0;
    waitHigh(0, "next fetch");
    check("next address", 32'h0000_1020, descAddr);
    repeat (8) @(posedge ref_clk);
    rd(ST, 32'h0070_0004, 32'h0060_0004, "suspended");
    wr(OM, 32'h0220_2000);
    rd(ST, 32'h0070_0000, 32'h0060_0000, "start ignored");
    // Poll demand resumes fetching; still unowned, so it suspends again
    @(posedge ref_clk);
    pollDemand <= 1'b1;
    @(posedge ref_clk);
    pollDemand <= 1'b0;
    waitHigh(0, "poll resume");
    repeat (8) @(posedge ref_clk);
    rd(ST, 32'h0070_0000, 32'h0060_0000, "suspended again");
    wr(OM, 32'h0220_0000);
    rd(ST, 32'h0070_0000, 32'h0000_0000, "stop from suspended");
    ownedCfg <= 1'b1;
    slow <= 1'b0;
    fifoLevel <= 12'h048;
    wr(OM, 32'h0240_3400);
    waitHigh(0, "fetch forced");
    check("suspended position", 32'h0000_1020, descAddr);
    check("force collision", 32'h0000_0001, 32'(forceCollision));
    noStart(6);
    startNow(12'h049, 1'b0);
    wr(OM, 32'h0240_3400);
    rd(ST, 32'h0070_0000, 32'h0020_0000, "start while sending");
    waitHigh(1, "excess collision");
    wr(OM, 32'h0240_0000);
    repeat (20) @(posedge ref_clk);
    rd(ST, 32'h0070_0000, 32'h0000_0000, "final stop");
    // A write while the clock enable is low must not land
    @(posedge ref_clk);
    clkEn <= 1'b0;
    wr(OM, 32'h0200_2000);
    clkEn <= 1'b1;
    rd(OM, 32'hFFFF_FFFF, 32'h0240_0000, "write while frozen");
    rd(ST, 32'h0070_0000, 32'h0000_0000, "state while frozen");
    wr(8'h3C, 32'hFFFF_FFFF);
    rd(8'h3C, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped");
    stop_test();
  end
endmodule // opmode_ctrl_tb
